// >>> hw/acv_pkg.sv
// Constants, field layout and carrier types of the converter sequencing block
package acv_pkg;
  // Timing: converter clock derived from aclk (125 MHz) by ADC_DIV
  localparam int CLK_NS      = 8;
  localparam int ADC_DIV     = 6;
  localparam int ADC_NS      = CLK_NS * ADC_DIV;
  // Trigger to sampling is 2.5 converter clocks, counted in aclk cycles
  localparam int START_HALVES = 5;
  localparam int START_CYC   = (START_HALVES * ADC_DIV) / 2;
  localparam int PIPE_STAGES = 4;
  localparam int SEQ_GAP     = 1;
  localparam int SIM_GAP     = 2;
  localparam int FLAG_DLY    = 2;
  // Power-up figures kept for software reference only
  localparam int BGR_MAX_MS  = 10;
  localparam int PWD_MIN_US  = 20;

  // Register byte offsets
  localparam logic [7:0] CTRL1_OFS  = 8'h00;
  localparam logic [7:0] CTRL2_OFS  = 8'h04;
  localparam logic [7:0] CTRL3_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS   = 8'h0C;
  localparam logic [7:0] RES_A_OFS  = 8'h10;
  localparam logic [7:0] RES_B_OFS  = 8'h14;

  // Field positions
  localparam int CH_LSB    = 0;
  localparam int MODE_BIT  = 4;
  localparam int ACQ_LSB   = 8;
  localparam int SWT_BIT   = 0;
  localparam int CONT_BIT  = 1;
  localparam int EXT_BIT   = 2;
  localparam int EVT_BIT   = 3;
  localparam int REF_LSB   = 6;
  localparam int PWR_BIT   = 5;
  localparam int BUSY_BIT  = 0;
  localparam int DONE_BIT  = 1;

  // Reset values
  localparam logic [3:0] CH_RST   = 4'h0;
  localparam logic [3:0] ACQ_RST  = 4'h0;
  localparam logic [1:0] REF_RST  = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] acqps;
    logic       mode;
    logic [3:0] chan;
  } acv_cfg_s;

  typedef struct packed {
    logic [11:0] a;
    logic [11:0] b;
  } acv_pair_s;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_HOLD  = 4'b0100,
    ST_GAP   = 4'b1000
  } acv_state_e;
endpackage

// >>> hw/acv_ctrl.sv
// Converter power, trigger and sample/hold sequencing with AXI4-Lite regs
`timescale 1ns/10ps

// Notes on behaviour
// - One write may clear both reference bits and converter power.
// - Mode bit 0 samples one channel, 1 samples a channel pair.
// - Sixteen inputs, chosen by software, one or two at a time.
// - Results are 12 bits: A from a four-stage pipeline, the B half of a pair from five stages.
// - Conversions start from event unit, software or external pin.
// - Sequential mode gives one result per pulse, repeating only when continuous is set.
// - Sequential mode samples on each falling edge of sample/hold.
// - Sample/hold pulse lasts one plus prescale converter clocks.
// - Sampling begins 2.5 converter clocks after a trigger.
// - First sequential result lands four converter clocks after sampling.
// - Later sequential results follow every two plus prescale clocks.
// - Done flag sets a few cycles after the result update.
// - Simultaneous mode samples a same-index pair on the falling edge.
module acv_ctrl (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               event_trigger,
  input  wire logic               external_conversion_start,
  input  wire acv_pkg::acv_pair_s conv_in,
  output logic                    sample_hold,
  output logic [3:0]              chan_a_sel,
  output logic [3:0]              chan_b_sel,
  output acv_pkg::acv_pair_s      result,
  output logic                    conversion_done,
  output logic [1:0]              reference_power_bits,
  output logic                    converter_power_bit
);
  import acv_pkg::*;

  // Bus slave state
  logic              aw_hold;
  logic [7:0]        aw_addr_q;
  logic              w_hold;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;

  // Software state
  acv_cfg_s          cfg;
  logic              continuous;
  logic              ext_en;
  logic              evt_en;
  logic              sw_trig;

  // Pin synchronisers
  logic [2:0]        ext_sync;
  logic [2:0]        evt_sync;

  // Sequencer
  acv_state_e        state;
  acv_state_e        next_state;
  logic [4:0]        start_cnt;
  logic [2:0]        phase;
  logic [3:0]        tcnt;
  logic              pipe_v [PIPE_STAGES+1];
  logic              pipe_m [PIPE_STAGES+1];
  acv_pair_s         pipe_d [PIPE_STAGES+1];
  logic [FLAG_DLY-1:0] flag_dly;

  // Write decode
  wire        do_write  = aw_hold && w_hold && !s_axi_bvalid;
  wire        wr_ctrl1  = do_write && (aw_addr_q == CTRL1_OFS);
  wire        wr_ctrl2  = do_write && (aw_addr_q == CTRL2_OFS);
  wire        wr_ctrl3  = do_write && (aw_addr_q == CTRL3_OFS);
  wire        wr_stat   = do_write && (aw_addr_q == STAT_OFS);
  wire        wr_hit    = wr_ctrl1 || wr_ctrl2 || wr_ctrl3 || wr_stat ||
                          (aw_addr_q == RES_A_OFS) ||
                          (aw_addr_q == RES_B_OFS);
  wire        lane0     = w_strb_q[0];
  wire        lane1     = w_strb_q[1];

  // Read decode
  wire        rd_take   = s_axi_arvalid && s_axi_arready;
  wire        busy      = (state != ST_IDLE);
  wire [31:0] ctrl1_rd  = {20'h00000, cfg.acqps, 3'h0, cfg.mode, cfg.chan};
  wire [31:0] ctrl2_rd  = {28'h0000000, evt_en, ext_en, continuous, 1'b0};
  wire [31:0] ctrl3_rd  = {24'h000000, reference_power_bits,
                           converter_power_bit, 5'h00};
  wire [31:0] stat_rd   = {30'h00000000, conversion_done, busy};
  wire [31:0] res_a_rd  = {20'h00000, result.a};
  wire [31:0] res_b_rd  = {20'h00000, result.b};
  wire        rd_hit    = (s_axi_araddr == CTRL1_OFS) ||
                          (s_axi_araddr == CTRL2_OFS) ||
                          (s_axi_araddr == CTRL3_OFS) ||
                          (s_axi_araddr == STAT_OFS)  ||
                          (s_axi_araddr == RES_A_OFS) ||
                          (s_axi_araddr == RES_B_OFS);
  wire [31:0] rd_mux    =
    (s_axi_araddr == CTRL1_OFS) ? ctrl1_rd :
    (s_axi_araddr == CTRL2_OFS) ? ctrl2_rd :
    (s_axi_araddr == CTRL3_OFS) ? ctrl3_rd :
    (s_axi_araddr == STAT_OFS)  ? stat_rd  :
    (s_axi_araddr == RES_A_OFS) ? res_a_rd :
    (s_axi_araddr == RES_B_OFS) ? res_b_rd : 32'h00000000;

  // Trigger sources; edges are taken from the second and third stages only
  wire ext_rise  = ext_sync[1] && !ext_sync[2];
  wire evt_rise  = evt_sync[1] && !evt_sync[2];
  wire any_trig  = sw_trig || (ext_en && ext_rise) ||
                   (evt_en && evt_rise);
  wire trig_ok   = any_trig && converter_power_bit &&
                   (state == ST_IDLE);

  // Converter clock ticks; phase restarts once, when the start delay ends, so edges align
  wire       tick      = (phase == 3'(ADC_DIV - 1));
  wire       start_end = (start_cnt == 5'(START_CYC - 1));
  wire       hold_end  = tick && (tcnt == cfg.acqps);
  wire [3:0] gap_len   = cfg.mode ? 4'(SIM_GAP) : 4'(SEQ_GAP);
  wire       gap_end   = tick && (tcnt == 4'(gap_len - 4'h1));
  wire       capture   = (state == ST_HOLD) && hold_end;
  wire       again     = continuous && converter_power_bit;

  // Result writes leave the pipeline after four or five ticks
  wire       wr_res_a  = tick && pipe_v[PIPE_STAGES-1];
  wire       wr_res_b  = tick && pipe_v[PIPE_STAGES] &&
                         pipe_m[PIPE_STAGES];
  wire       res_last  = (wr_res_a && !pipe_m[PIPE_STAGES-1]) || wr_res_b;
  wire       done_clr  = wr_stat && lane0 && w_data_q[DONE_BIT];

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Pair mode uses A and B inputs of the same index
  assign chan_a_sel = cfg.mode ? {1'b0, cfg.chan[2:0]} : cfg.chan;
  assign chan_b_sel = {1'b1, cfg.chan[2:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold   <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold   <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold   <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold   <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // One process owns the whole config struct; lanes gate its fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.chan  <= CH_RST;
      cfg.mode  <= 1'b0;
      cfg.acqps <= ACQ_RST;
    end else begin
      if (wr_ctrl1 && lane0) begin
        cfg.chan  <= w_data_q[CH_LSB +: 4];
        cfg.mode  <= w_data_q[MODE_BIT];
      end
      if (wr_ctrl1 && lane1) begin
        cfg.acqps <= w_data_q[ACQ_LSB +: 4];
      end
    end
  end

  // Software trigger is a one-cycle pulse, it never reads back as set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      continuous <= 1'b0;
      ext_en     <= 1'b0;
      evt_en     <= 1'b0;
      sw_trig    <= 1'b0;
    end else begin
      sw_trig    <= wr_ctrl2 && lane0 && w_data_q[SWT_BIT];
      if (wr_ctrl2 && lane0) begin
        continuous <= w_data_q[CONT_BIT];
        ext_en     <= w_data_q[EXT_BIT];
        evt_en     <= w_data_q[EVT_BIT];
      end
    end
  end

  // Power bits are independent; one write may clear all three
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reference_power_bits <= REF_RST;
      converter_power_bit  <= 1'b0;
    end else if (wr_ctrl3 && lane0) begin
      reference_power_bits <= w_data_q[REF_LSB +: 2];
      converter_power_bit  <= w_data_q[PWR_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync <= 3'h0;
      evt_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], external_conversion_start};
      evt_sync <= {evt_sync[1:0], event_trigger};
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (trig_ok) next_state = ST_START;
      ST_START: if (start_end) next_state = ST_HOLD;
      ST_HOLD:  if (hold_end) next_state = ST_GAP;
      ST_GAP:   if (gap_end) next_state = again ? ST_HOLD : ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
    // Losing power aborts the sequence at once
    if (!converter_power_bit) next_state = ST_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_cnt <= 5'h00;
    end else if (state == ST_START) begin
      start_cnt <= start_cnt + 5'h01;
    end else begin
      start_cnt <= 5'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 3'h0;
    end else if (state == ST_START && start_end) begin
      phase <= 3'h0;
    end else begin
      phase <= tick ? 3'h0 : phase + 3'h1;
    end
  end

  // Tick counter restarts at each state change, counting the high part and then the gap of each pulse separately
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tcnt <= 4'h0;
    end else if (state != next_state) begin
      tcnt <= 4'h0;
    end else if (tick) begin
      tcnt <= tcnt + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= (next_state == ST_HOLD);
    end
  end

  // Four stages for the A result, one more for the B half of a pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i <= PIPE_STAGES; i++) begin
        pipe_v[i] <= 1'b0;
        pipe_m[i] <= 1'b0;
        pipe_d[i] <= '0;
      end
    end else if (tick) begin
      pipe_v[0] <= capture;
      pipe_m[0] <= cfg.mode;
      pipe_d[0] <= conv_in;
      for (int i = 1; i <= PIPE_STAGES; i++) begin
        pipe_v[i] <= pipe_v[i-1];
        pipe_m[i] <= pipe_m[i-1];
        pipe_d[i] <= pipe_d[i-1];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= '0;
    end else begin
      if (wr_res_a) begin
        result.a <= pipe_d[PIPE_STAGES-1].a;
      end
      if (wr_res_b) begin
        result.b <= pipe_d[PIPE_STAGES].b;
      end
    end
  end

  // Flag trails the final result write; a new set beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_dly        <= '0;
      conversion_done <= 1'b0;
    end else begin
      flag_dly        <= {flag_dly[FLAG_DLY-2:0], res_last};
      if (flag_dly[FLAG_DLY-1]) begin
        conversion_done <= 1'b1;
      end else if (done_clr) begin
        conversion_done <= 1'b0;
      end
    end
  end
endmodule

// >>> verif/acv_ctrl_asserts.sv
// Port-level checks of the converter sequencing block
`timescale 1ns/10ps
module acv_ctrl_asserts (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_bvalid,
  input wire logic               sample_hold,
  input wire logic [3:0]         chan_a_sel,
  input wire logic [3:0]         chan_b_sel,
  input wire acv_pkg::acv_pair_s result,
  input wire logic               conversion_done,
  input wire logic               converter_power_bit
);
  import acv_pkg::*;
  logic [7:0] hi_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn || !sample_hold)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= hi_cnt + 8'h01;
  end
  // An abort cuts a pulse short, so only whole pulses are measured
  a_hold_width: assert property (
    $fell(sample_hold) && converter_power_bit |->
      hi_cnt % ADC_DIV == 0 && hi_cnt >= 6 && hi_cnt <= 96)
    else $error("sample/hold width off");
  a_result_lat: assert property (
    $changed(result.a) |-> $past(sample_hold, 25) && !$past(sample_hold, 24))
    else $error("result A written off schedule");
  a_done_lat: assert property (
    $rose(conversion_done) |->
      ($past(sample_hold, 27) && !$past(sample_hold, 26)) ||
      ($past(sample_hold, 33) && !$past(sample_hold, 32)))
    else $error("done flag off schedule");
  a_power_gate: assert property (
    $rose(sample_hold) |-> converter_power_bit &&
      $past(converter_power_bit, 16))
    else $error("sampling without converter power");
  a_min_gap: assert property (
    $fell(sample_hold) |-> !sample_hold [*6])
    else $error("gap between pulses too short");
  a_chan_pair: assert property (
    chan_b_sel[3] && chan_b_sel[2:0] == chan_a_sel[2:0])
    else $error("channel pair mismatch");
  a_done_clear: assert property (
    $fell(conversion_done) |-> $rose(s_axi_bvalid))
    else $error("done cleared without a write");
  a_abort_stop: assert property (
    $fell(converter_power_bit) |-> ##2 !sample_hold [*8])
    else $error("sampling after power off");
endmodule

// >>> verif/acv_partner.sv
// Far side: analog channel values and trigger pins
`timescale 1ns/10ps
module acv_partner (
  input  wire logic          aclk,
  input  wire logic [3:0]    chan_a_sel,
  input  wire logic [3:0]    chan_b_sel,
  output acv_pkg::acv_pair_s conv_in,
  output logic               event_trigger,
  output logic               external_conversion_start
);
  import acv_pkg::*;
  // Each input reads back a value naming its channel
  assign conv_in.a = {8'hA3, chan_a_sel};
  assign conv_in.b = {8'h5C, chan_b_sel};
  initial begin
    event_trigger = 1'b0;
    external_conversion_start = 1'b0;
  end
  // Held four edges so the three-stage synchroniser cannot miss it
  task pulse(input logic ext);
    @(posedge aclk);
    if (ext)
      external_conversion_start <= 1'b1;
    else
      event_trigger <= 1'b1;
    repeat (4) @(posedge aclk);
    external_conversion_start <= 1'b0;
    event_trigger <= 1'b0;
  endtask
endmodule

// >>> verif/test_acv_ctrl.sv
// Bench for the converter sequencing block
`timescale 1ns/10ps
module test_acv_ctrl;
  import acv_pkg::*;
  // Band gap wait cut to keep the run short; the design does not time it
  localparam int BGR_WAIT = 200;
  localparam int PWD_WAIT = 2500;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic        awr, wr_rdy, bv, arr, rv, sh, done, pwr, evt, ext;
  logic [1:0]  br, rr, refp;
  logic [3:0]  csa, csb;
  acv_pair_s   cin, res;
  int          n_errors = 0;
  int          check_count = 0;
  logic [31:0] cfg [4] = '{32'h9, 32'hF0F, 32'h300, 32'h1A};
  int          srcs [4] = '{0, 0, 1, 2};

  always #4 aclk = ~aclk;

  acv_ctrl i_acv_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .event_trigger(evt),
    .external_conversion_start(ext), .conv_in(cin), .sample_hold(sh),
    .chan_a_sel(csa), .chan_b_sel(csb), .result(res),
    .conversion_done(done), .reference_power_bits(refp),
    .converter_power_bit(pwr));

  acv_partner i_acv_partner (
    .aclk(aclk), .chan_a_sel(csa), .chan_b_sel(csb), .conv_in(cin),
    .event_trigger(evt), .external_conversion_start(ext));

  task close_out;
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task tmo;
    n_errors++;
    close_out();
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    for (t = 0; t < 64; t++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (bv) break;
    end
    if (t == 64) tmo();
    bre <= 1'b0;
    check(br, RESP_OKAY);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int t;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (t = 0; t < 64; t++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    if (t == 64) tmo();
    rre <= 1'b0;
    check(rd, e);
    check(rr, er);
  endtask

  // Counts edges until sample/hold (or done) shows the wanted level
  task wt(input logic v, input logic on_done, output int n);
    for (n = 1; n < 3000; n++) begin
      @(posedge aclk);
      if ((on_done ? done : sh) === v) break;
    end
    if (n == 3000) tmo();
  endtask

  task quiet;
    logic s;
    s = 1'b0;
    repeat (3) @(posedge aclk);
    repeat (40) begin
      @(posedge aclk);
      s = s | sh;
    end
    check(s, 1'b0);
  endtask

  task powerup;
    wr(CTRL3_OFS, 32'hC0);
    check({refp, pwr}, 3'h6);
    repeat (BGR_WAIT) @(posedge aclk);
    wr(CTRL3_OFS, 32'hE0);
    check({refp, pwr}, 3'h7);
    repeat (PWD_WAIT) @(posedge aclk);
  endtask

  task shot(input logic [31:0] c, input int src);
    int n;
    wr(CTRL1_OFS, c);
    wr(CTRL2_OFS, src == 0 ? 32'h1 : (src == 1 ? 32'h8 : 32'h4));
    if (src != 0) i_acv_partner.pulse(src == 2);
    wt(1'b1, 1'b0, n);
    if (src == 0) check(32'(n >= 15 && n <= 19), 32'h1);
    wt(1'b0, 1'b0, n);
    check(n, (1 + c[11:8]) * ADC_DIV);
    wt(1'b1, 1'b1, n);
    check(n, c[4] ? 32 : 26);
  endtask

  initial begin
    int i, n, k;
    logic [3:0] ea;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(CTRL3_OFS, 32'h0, RESP_OKAY);
    rchk(8'h20, 32'h0, RESP_SLVERR);
    wr(CTRL2_OFS, 32'h1);
    quiet();
    powerup();
    rchk(CTRL3_OFS, 32'hE0, RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      shot(cfg[i], srcs[i]);
      ea = cfg[i][4] ? {1'b0, cfg[i][2:0]} : cfg[i][3:0];
      rchk(RES_A_OFS, {20'h0, 8'hA3, ea}, RESP_OKAY);
      if (cfg[i][4])
        rchk(RES_B_OFS, {20'h0, 8'h5C, 1'b1, ea[2:0]}, RESP_OKAY);
      wr(STAT_OFS, 32'h2);
      rchk(STAT_OFS, 32'h0, RESP_OKAY);
    end
    for (i = 0; i < 2; i++) begin
      wr(CTRL1_OFS, 32'h105 | 32'(i << 4));
      wr(CTRL2_OFS, 32'h3);
      wt(1'b1, 1'b0, n);
      wt(1'b0, 1'b0, n);
      wt(1'b1, 1'b0, n);
      wt(1'b0, 1'b0, k);
      check(n + k, (3 + i) * ADC_DIV);
      wr(CTRL3_OFS, 32'h0);
      check({refp, pwr}, 3'h0);
      quiet();
      rchk(CTRL3_OFS, 32'h0, RESP_OKAY);
      powerup();
    end
    close_out();
  end
endmodule

bind acv_ctrl acv_ctrl_asserts i_acv_ctrl_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .sample_hold(sample_hold), .chan_a_sel(chan_a_sel),
  .chan_b_sel(chan_b_sel), .result(result),
  .conversion_done(conversion_done),
  .converter_power_bit(converter_power_bit));
